// ---- logic/vbre_regs.vh ----
// register offsets, field positions, codes and reset values of the engine
`ifndef VBRE_REGS_VH
`define VBRE_REGS_VH
`define VBRE_OFF_DEV_FEAT   12'h000
`define VBRE_OFF_DRV_FEAT   12'h004
`define VBRE_OFF_DEV_STAT   12'h008
`define VBRE_OFF_CTRL       12'h00c
`define VBRE_OFF_CAP_LO     12'h010
`define VBRE_OFF_CAP_HI     12'h014
`define VBRE_OFF_SEG_SIZE   12'h018
`define VBRE_OFF_SEG_CNT    12'h01c
`define VBRE_OFF_CYL        12'h020
`define VBRE_OFF_HEADS      12'h024
`define VBRE_OFF_SPT        12'h028
`define VBRE_OFF_BLK_BYTES  12'h02c
`define VBRE_OFF_PHYS_LOG2  12'h030
`define VBRE_OFF_ALIGN      12'h034
`define VBRE_OFF_MIN_XFER   12'h038
`define VBRE_OFF_OPT_XFER   12'h03c
`define VBRE_OFF_CACHE      12'h040
`define VBRE_OFF_DONE_CNT   12'h044
`define VBRE_OFF_ENG_STAT   12'h048
`define VBRE_OFF_ID         12'h04c
// feature bit positions
`define VBRE_F_BARRIER      0
`define VBRE_F_SEG_SIZE     1
`define VBRE_F_SEG_CNT      2
`define VBRE_F_GEOMETRY     4
`define VBRE_F_READ_ONLY    5
`define VBRE_F_BLK_SIZE     6
`define VBRE_F_SCSI         7
`define VBRE_F_FLUSH        9
`define VBRE_F_TOPOLOGY     10
`define VBRE_F_SW_CACHE     11
// device status and control bits
`define VBRE_S_DRIVER_OK    2
`define VBRE_S_FEAT_OK      3
`define VBRE_C_LEGACY       0
`define VBRE_C_GUEST_BE     1
// request type and completion codes
`define VBRE_T_READ         32'h0000_0000
`define VBRE_T_WRITE        32'h0000_0001
`define VBRE_T_FLUSH        32'h0000_0004
`define VBRE_ST_OK          8'h00
`define VBRE_ST_IOERR       8'h01
`define VBRE_ST_UNSUPP      8'h02
// backend operation codes
`define VBRE_OP_READ        2'h0
`define VBRE_OP_WRITE       2'h1
`define VBRE_OP_FLUSH       2'h2
// 512-byte sector is a shift by this
`define VBRE_SECTOR_SHIFT   9
`define VBRE_CACHE_RESET    1'b1
`endif

// ---- logic/vbre_top.v ----
// virtual block request engine: config space on apb and request sequencer
// Notes on behaviour
// - feature bits 1, 2, 4 flag segment size, segment count, geometry valid
// - feature bit 5 read-only, bit 6 preferred block size valid
// - bit 9 flush, bit 10 topology, bit 11 switchable cache mode
// - legacy mode offers bit 0 barrier and bit 7 packet commands
// - capacity always present in sectors; segment, geometry, block size and topology fields read zero unless offered
// - legacy big-endian guest sees multi-byte fields byte-swapped
// - request sector unit stays 512 bytes regardless of block size fields
// - read-only device fails every write request
// - switchable cache negotiated: cache byte is writable, 0 through, 1 back
// - reset cache mode is the VBRE_CACHE_RESET define in the header; byte shows mode in effect
// - flush is offered whenever switchable cache is offered
// - non-legacy: switchable without flush negotiated zeroes cache byte at features-ok
// - legacy: status writes leave cache alone except driver-ok without switch
// - legacy: driver feature writes never change the cache mode
// - one request queue; completions carry a tag and come in request order
// - request has type, reserved, sector, 512-byte chunks, status byte
// - byte offset is sector times 512; flush ignores the sector
// - status byte 0 ok, 1 error, 2 unsupported
// - read-only write gets error status and storage is not touched
module vbre_top #(
    parameter [63:0] CAPACITY   = 64'h0000_0000_0010_0000,
    parameter [31:0] SEG_SIZE   = 32'h0001_0000,
    parameter [31:0] SEG_CNT    = 32'h0000_0080,
    parameter [15:0] CYLINDERS  = 16'h0400,
    parameter [7:0]  HEADS      = 8'h10,
    parameter [7:0]  SPT        = 8'h3f,
    parameter [31:0] BLK_BYTES  = 32'h0000_1000,
    parameter [7:0]  PHYS_LOG2  = 8'h03,
    parameter [7:0]  ALIGN_OFF  = 8'h00,
    parameter [15:0] MIN_XFER   = 16'h0001,
    parameter [31:0] OPT_XFER   = 32'h0000_0100,
    // which optional features the device offers
    parameter        OFFER_SEG  = 1,
    parameter        OFFER_GEOM = 1,
    parameter        OFFER_RO   = 0,
    parameter        OFFER_BLK  = 1,
    parameter        OFFER_TOPO = 1,
    parameter        OFFER_SWC  = 1,
    parameter        OFFER_FLSH = 1,
    parameter        OFFER_BAR  = 0,
    parameter        OFFER_SCSI = 0,
    // arbitrary identification value
    parameter [31:0] DEVICE_ID  = 32'h0000_5a5a
) (
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output reg         pslverr,
    // request queue
    input  wire        req_valid,
    output wire        req_ready,
    input  wire [15:0] req_tag,
    input  wire [31:0] req_type,
    input  wire [31:0] req_reserved,
    input  wire [63:0] req_sector,
    input  wire [15:0] req_chunks,
    // storage backend
    output wire        be_valid,
    input  wire        be_ready,
    output reg  [1:0]  be_op,
    output reg  [63:0] be_offset,
    output reg  [15:0] be_chunks,
    input  wire        be_done,
    input  wire        be_error,
    // completion
    output wire        cpl_valid,
    input  wire        cpl_ready,
    output reg  [15:0] cpl_tag,
    output reg  [7:0]  cpl_status
);
`include "vbre_regs.vh"

    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_ISSUE = 2'h1;
    localparam [1:0] ST_WAIT  = 2'h2;
    localparam [1:0] ST_CPL   = 2'h3;

    function [15:0] swap16;
        input [15:0] v;
        swap16 = {v[7:0], v[15:8]};
    endfunction
    function [31:0] swap32;
        input [31:0] v;
        swap32 = {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction
    function [63:0] swap64;
        input [63:0] v;
        swap64 = {swap32(v[31:0]), swap32(v[63:32])};
    endfunction

    reg [31:0] drv_feat_q;
    reg [7:0]  dev_stat_q;
    reg [1:0]  ctrl_q;
    reg        cache_q;
    reg        cache_d;
    reg [31:0] done_cnt_q;
    reg [7:0]  last_status_q;
    reg [1:0]  state_q;
    reg [1:0]  state_d;

    wire legacy = ctrl_q[`VBRE_C_LEGACY];
    wire swap   = legacy & ctrl_q[`VBRE_C_GUEST_BE];
    wire [63:0] cap_sw = swap64(CAPACITY);

    // offered features; flush is forced on with switchable cache
    wire [31:0] dev_feat;
    assign dev_feat[`VBRE_F_BARRIER]  = (OFFER_BAR != 0) & legacy;
    assign dev_feat[`VBRE_F_SEG_SIZE] = (OFFER_SEG != 0);
    assign dev_feat[`VBRE_F_SEG_CNT]  = (OFFER_SEG != 0);
    assign dev_feat[3]                = 1'b0;
    assign dev_feat[`VBRE_F_GEOMETRY] = (OFFER_GEOM != 0);
    assign dev_feat[`VBRE_F_READ_ONLY] = (OFFER_RO != 0);
    assign dev_feat[`VBRE_F_BLK_SIZE] = (OFFER_BLK != 0);
    assign dev_feat[`VBRE_F_SCSI]     = (OFFER_SCSI != 0) & legacy;
    assign dev_feat[8]                = 1'b0;
    assign dev_feat[`VBRE_F_FLUSH]    =
        (OFFER_FLSH != 0) | (OFFER_SWC != 0);
    assign dev_feat[`VBRE_F_TOPOLOGY] = (OFFER_TOPO != 0);
    assign dev_feat[`VBRE_F_SW_CACHE] = (OFFER_SWC != 0);
    assign dev_feat[31:12]            = 20'h00000;

    // negotiated = offered and accepted by the driver
    wire [31:0] neg   = dev_feat & drv_feat_q;
    wire neg_swc      = neg[`VBRE_F_SW_CACHE];
    wire neg_flush    = neg[`VBRE_F_FLUSH];
    wire read_only    = dev_feat[`VBRE_F_READ_ONLY];

    // apb decode
    wire setup   = psel & ~penable;
    wire wr_acc  = psel & penable & pwrite;
    assign pready = 1'b1;

    wire wr_drv  = wr_acc & (paddr == `VBRE_OFF_DRV_FEAT);
    wire wr_stat = wr_acc & (paddr == `VBRE_OFF_DEV_STAT);
    wire wr_ctrl = wr_acc & (paddr == `VBRE_OFF_CTRL);
    wire wr_cach = wr_acc & (paddr == `VBRE_OFF_CACHE);

    wire feat_ok_rise = wr_stat & pwdata[`VBRE_S_FEAT_OK] &
                        ~dev_stat_q[`VBRE_S_FEAT_OK];
    wire drv_ok_rise  = wr_stat & pwdata[`VBRE_S_DRIVER_OK] &
                        ~dev_stat_q[`VBRE_S_DRIVER_OK];

    // cache mode: one bit is enough, only 0 and 1 are defined
    always @* begin
        cache_d = cache_q;
        if (!legacy && feat_ok_rise && neg_swc && !neg_flush)
            cache_d = 1'b0;
        else if (!legacy && feat_ok_rise && !neg_swc)
            cache_d = neg_flush;
        else if (legacy && drv_ok_rise && !drv_feat_q[`VBRE_F_SW_CACHE])
            cache_d = neg_flush;
        // feature writes alone never reach cache_d
        if (wr_cach && (neg_swc || legacy))
            cache_d = pwdata[0];
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drv_feat_q <= 32'h0000_0000;
            dev_stat_q <= 8'h00;
            ctrl_q     <= 2'h0;
            cache_q    <= `VBRE_CACHE_RESET;
        end else begin
            if (wr_drv)
                drv_feat_q <= pwdata & dev_feat;
            if (wr_stat)
                dev_stat_q <= pwdata[7:0];
            if (wr_ctrl)
                ctrl_q <= pwdata[1:0];
            cache_q <= cache_d;
        end
    end

    // read mux; optional fields read zero unless offered
    reg [31:0] rd_val;
    reg        rd_err;
    always @* begin
        rd_val = 32'h0000_0000;
        rd_err = 1'b0;
        case (paddr)
            `VBRE_OFF_DEV_FEAT:  rd_val = dev_feat;
            `VBRE_OFF_DRV_FEAT:  rd_val = drv_feat_q;
            `VBRE_OFF_DEV_STAT:  rd_val = {24'h000000, dev_stat_q};
            `VBRE_OFF_CTRL:      rd_val = {30'h00000000, ctrl_q};
            `VBRE_OFF_CAP_LO:
                rd_val = swap ? cap_sw[31:0]
                              : CAPACITY[31:0];
            `VBRE_OFF_CAP_HI:
                rd_val = swap ? cap_sw[63:32]
                              : CAPACITY[63:32];
            `VBRE_OFF_SEG_SIZE:
                if (dev_feat[`VBRE_F_SEG_SIZE])
                    rd_val = swap ? swap32(SEG_SIZE) : SEG_SIZE;
            `VBRE_OFF_SEG_CNT:
                if (dev_feat[`VBRE_F_SEG_CNT])
                    rd_val = swap ? swap32(SEG_CNT) : SEG_CNT;
            `VBRE_OFF_CYL:
                if (dev_feat[`VBRE_F_GEOMETRY])
                    rd_val = {16'h0000,
                              swap ? swap16(CYLINDERS) : CYLINDERS};
            `VBRE_OFF_HEADS:
                if (dev_feat[`VBRE_F_GEOMETRY])
                    rd_val = {24'h000000, HEADS};
            `VBRE_OFF_SPT:
                if (dev_feat[`VBRE_F_GEOMETRY])
                    rd_val = {24'h000000, SPT};
            `VBRE_OFF_BLK_BYTES:
                if (dev_feat[`VBRE_F_BLK_SIZE])
                    rd_val = swap ? swap32(BLK_BYTES) : BLK_BYTES;
            `VBRE_OFF_PHYS_LOG2:
                if (dev_feat[`VBRE_F_TOPOLOGY])
                    rd_val = {24'h000000, PHYS_LOG2};
            `VBRE_OFF_ALIGN:
                if (dev_feat[`VBRE_F_TOPOLOGY])
                    rd_val = {24'h000000, ALIGN_OFF};
            `VBRE_OFF_MIN_XFER:
                if (dev_feat[`VBRE_F_TOPOLOGY])
                    rd_val = {16'h0000,
                              swap ? swap16(MIN_XFER) : MIN_XFER};
            `VBRE_OFF_OPT_XFER:
                if (dev_feat[`VBRE_F_TOPOLOGY])
                    rd_val = swap ? swap32(OPT_XFER) : OPT_XFER;
            `VBRE_OFF_CACHE:     rd_val = {31'h00000000, cache_q};
            `VBRE_OFF_DONE_CNT:  rd_val = done_cnt_q;
            `VBRE_OFF_ENG_STAT:
                rd_val = {22'h000000, state_q, last_status_q};
            `VBRE_OFF_ID:        rd_val = DEVICE_ID;
            default:             rd_err = 1'b1;
        endcase
    end

    // read data is captured in the setup cycle so the access needs no wait
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_val;
            pslverr <= rd_err;
        end
    end

    // request sequencer; serial, so completions return in request order
    wire [31:0] rtype   = swap ? swap32(req_type) : req_type;
    wire [63:0] rsector = swap ? swap64(req_sector) : req_sector;
    wire is_read  = (rtype == `VBRE_T_READ);
    wire is_write = (rtype == `VBRE_T_WRITE);
    wire is_flush = (rtype == `VBRE_T_FLUSH);
    wire take     = req_valid & req_ready;

    assign req_ready = (state_q == ST_IDLE);
    assign be_valid  = (state_q == ST_ISSUE);
    assign cpl_valid = (state_q == ST_CPL);

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
                if (take) begin
                    if (is_write && read_only)
                        state_d = ST_CPL;
                    else if (is_read || is_write || is_flush)
                        state_d = ST_ISSUE;
                    else
                        state_d = ST_CPL;
                end
            ST_ISSUE:
                if (be_ready)
                    state_d = ST_WAIT;
            ST_WAIT:
                if (be_done)
                    state_d = ST_CPL;
            ST_CPL:
                if (cpl_ready)
                    state_d = ST_IDLE;
            default:
                state_d = ST_IDLE;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q       <= ST_IDLE;
            be_op         <= `VBRE_OP_READ;
            be_offset     <= 64'h0000_0000_0000_0000;
            be_chunks     <= 16'h0000;
            cpl_tag       <= 16'h0000;
            cpl_status    <= `VBRE_ST_OK;
            last_status_q <= `VBRE_ST_OK;
            done_cnt_q    <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            if (state_q == ST_IDLE && take) begin
                cpl_tag <= req_tag;
                if (is_flush) begin
                    be_op     <= `VBRE_OP_FLUSH;
                    be_offset <= 64'h0000_0000_0000_0000;
                    be_chunks <= 16'h0000;
                end else begin
                    be_op     <= is_write ? `VBRE_OP_WRITE
                                          : `VBRE_OP_READ;
                    be_offset <= {rsector[63-`VBRE_SECTOR_SHIFT:0],
                                  {`VBRE_SECTOR_SHIFT{1'b0}}};
                    be_chunks <= req_chunks;
                end
                if (is_write && read_only)
                    cpl_status <= `VBRE_ST_IOERR;
                else if (!(is_read || is_write || is_flush))
                    cpl_status <= `VBRE_ST_UNSUPP;
            end
            if (state_q == ST_WAIT && be_done)
                cpl_status <= be_error ? `VBRE_ST_IOERR
                                       : `VBRE_ST_OK;
            if (cpl_valid && cpl_ready) begin
                last_status_q <= cpl_status;
                done_cnt_q    <= done_cnt_q + 32'h0000_0001;
            end
        end
    end

endmodule

// ---- verif/vbre_backend_model.sv ----
// storage backend model: accepts one operation, answers after a delay
module vbre_backend_model (
    // clock and reset
    input  wire        clk,
    input  wire        rstn,
    // operation from the engine
    input  wire        be_valid,
    input  wire [1:0]  be_op,
    input  wire [63:0] be_offset,
    output logic       be_ready,
    output logic       be_done,
    output logic       be_error,
    // bench control and record
    input  wire [3:0]  delay,
    input  wire        fail,
    output logic [1:0] last_op,
    output logic [63:0] last_off,
    output logic [7:0] n_ops
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_q;
    logic       busy_q;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {be_ready, be_done, be_error, busy_q} <= 4'h0;
            {wait_q, last_op, last_off, n_ops} <= '0;
        end else begin
            be_done  <= 1'b0;
            // error line means nothing outside a done pulse
            be_error <= ~fail;
            if (be_valid && be_ready) begin
                be_ready <= 1'b0;
                busy_q   <= 1'b1;
                wait_q   <= delay;
                last_op  <= be_op;
                last_off <= be_offset;
                n_ops    <= n_ops + 8'h01;
            end else if (busy_q) begin
                if (wait_q == 4'h0) begin
                    busy_q   <= 1'b0;
                    be_done  <= 1'b1;
                    be_error <= fail;
                end else wait_q <= wait_q - 4'h1;
            end else if (be_valid) begin
                if (wait_q >= delay) be_ready <= 1'b1;
                else wait_q <= wait_q + 4'h1;
            end
        end
    end
endmodule

// ---- verif/vbre_asserts.sv ----
// port checker for the request engine, bound into the top
`include "vbre_regs.vh"
module vbre_asserts #(parameter OFFER_RO = 0) (
    // clock, reset, apb
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire [11:0] paddr,
    input wire        pslverr,
    // request and completion
    input wire        req_valid,
    input wire        req_ready,
    input wire [15:0] req_tag,
    input wire [31:0] req_type,
    input wire [63:0] req_sector,
    input wire [15:0] req_chunks,
    input wire        cpl_valid,
    input wire        cpl_ready,
    input wire [15:0] cpl_tag,
    input wire [7:0]  cpl_status,
    // backend
    input wire        be_valid,
    input wire        be_ready,
    input wire [1:0]  be_op,
    input wire [63:0] be_offset,
    input wire [15:0] be_chunks,
    input wire        be_done,
    input wire        be_error
);
    reg  [15:0] tag_q;
    wire take = req_valid && req_ready;
    wire is_rd = req_type == `VBRE_T_READ;
    wire is_wr = req_type == `VBRE_T_WRITE;
    wire is_fl = req_type == `VBRE_T_FLUSH;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) tag_q <= 16'h0000;
        else if (take) tag_q <= req_tag;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_rw_take;
        take && (is_rd || (is_wr && OFFER_RO == 0));
    endsequence
    sequence s_issued;
        be_valid ##0 be_chunks == $past(req_chunks);
    endsequence
    AST_OFFSET: assert property (
        s_rw_take |=> s_issued ##0 be_offset == ($past(req_sector) << 9))
        else $error("read or write offset is not sector times 512");
    AST_FLUSH: assert property (
        take && is_fl |=> be_valid && be_op == `VBRE_OP_FLUSH
            && be_offset == 64'h0)
        else $error("flush not issued with zero offset");
    AST_UNSUPP: assert property (
        take && !(is_rd || is_wr || is_fl) |=> cpl_valid
            && cpl_status == `VBRE_ST_UNSUPP && !be_valid)
        else $error("unknown type not answered as unsupported");
    AST_RO_WRITE: assert property (
        take && is_wr && OFFER_RO != 0 |=> cpl_valid
            && cpl_status == `VBRE_ST_IOERR && !be_valid)
        else $error("write on read-only device not failed");
    AST_DONE_OK: assert property (
        be_done && !be_error && !cpl_valid |=> cpl_valid
            && cpl_status == `VBRE_ST_OK)
        else $error("good backend finish not completed as ok");
    AST_DONE_ERR: assert property (
        be_done && be_error && !cpl_valid |=> cpl_valid
            && cpl_status == `VBRE_ST_IOERR)
        else $error("backend error not completed as io error");
    AST_BE_HOLD: assert property (
        be_valid && !be_ready |=> be_valid && $stable(be_offset)
            && $stable(be_op))
        else $error("backend request dropped before ready");
    AST_CPL_HOLD: assert property (
        cpl_valid && !cpl_ready |=> cpl_valid && $stable(cpl_status))
        else $error("completion changed before it was taken");
    AST_TAG: assert property (
        cpl_valid |-> cpl_tag == tag_q && !req_ready && !be_valid)
        else $error("completion tag differs from the taken request");
    AST_APB_ERR: assert property (
        psel && !penable |=> pslverr == ($past(paddr) > 12'h04c))
        else $error("slave error does not match the address map");
endmodule
bind vbre_top vbre_asserts #(.OFFER_RO(OFFER_RO)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .pslverr(pslverr), .req_valid(req_valid),
    .req_ready(req_ready), .req_tag(req_tag), .req_type(req_type),
    .req_sector(req_sector), .req_chunks(req_chunks),
    .cpl_valid(cpl_valid), .cpl_ready(cpl_ready), .cpl_tag(cpl_tag),
    .cpl_status(cpl_status), .be_valid(be_valid), .be_ready(be_ready),
    .be_op(be_op), .be_offset(be_offset), .be_chunks(be_chunks),
    .be_done(be_done), .be_error(be_error));

// ---- verif/virtual_block_request_engine_tb.sv ----
// bench: apb register checks, cache negotiation and request traffic
`include "vbre_regs.vh"
module virtual_block_request_engine_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [63:0] CAP = 64'h0000_0001_0000_0800;
    localparam [31:0] SEG = 32'h0000_2000;
    localparam [7:0]  HDS = 8'h08;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, req_valid;
    logic req_ready, be_valid, be_ready, be_done, be_error, cpl_valid;
    logic cpl_ready, fail;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, req_type, req_reserved, q;
    logic [63:0] req_sector, be_offset, last_off;
    logic [15:0] req_tag, req_chunks, be_chunks, cpl_tag;
    logic [7:0]  cpl_status, n_ops, ops0;
    logic [1:0]  be_op, last_op;
    logic [3:0]  delay;
    logic        e;
    integer      failures = 0, n_checks = 0, k;
    vbre_top #(.CAPACITY(CAP), .SEG_SIZE(SEG), .HEADS(HDS),
        .OFFER_BAR(1), .OFFER_SCSI(1)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .req_valid(req_valid),
        .req_ready(req_ready), .req_tag(req_tag), .req_type(req_type),
        .req_reserved(req_reserved), .req_sector(req_sector),
        .req_chunks(req_chunks), .be_valid(be_valid), .be_ready(be_ready),
        .be_op(be_op), .be_offset(be_offset), .be_chunks(be_chunks),
        .be_done(be_done), .be_error(be_error), .cpl_valid(cpl_valid),
        .cpl_ready(cpl_ready), .cpl_tag(cpl_tag), .cpl_status(cpl_status));
    vbre_backend_model u_be (.clk(pclk), .rstn(presetn),
        .be_valid(be_valid), .be_op(be_op), .be_offset(be_offset),
        .be_ready(be_ready), .be_done(be_done), .be_error(be_error),
        .delay(delay), .fail(fail), .last_op(last_op),
        .last_off(last_off), .n_ops(n_ops));
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task wrap_up;
        if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // waits for a flag sampled at mid-cycle, so it equals the edge value
    task automatic wait_hi(ref logic f);
        integer i;
        logic ok;
        ok = 1'b0;
        for (i = 0; i < 60 && !ok; i = i + 1) begin
            @(negedge pclk);
            ok = f === 1'b1;
            @(posedge pclk);
        end
        if (!ok) begin
            failures = failures + 1;
            wrap_up;
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        wait_hi(pready);
        // taken at the edge where pready was seen high
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
        // one idle edge keeps the next call from re-driving psel at once
        @(posedge pclk);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp, input string n);
        apb(1'b0, a, 32'h0);
        chk(n, {32'h0, exp}, {32'h0, q});
    endtask
    task req(input logic [31:0] t, input logic [63:0] s,
             input logic [7:0] st, input logic f, input logic [3:0] dl);
        ops0 = n_ops;
        fail <= f;
        delay <= dl;
        req_valid <= 1'b1;
        req_tag <= req_tag + 16'h0101;
        req_type <= t;
        req_sector <= s;
        req_chunks <= (t == `VBRE_T_FLUSH) ? 16'h0 : 16'h0002;
        wait_hi(req_ready);
        req_valid <= 1'b0;
        req_sector <= ~s;
        wait_hi(cpl_valid);
        chk("cpl_status", {56'h0, st}, {56'h0, cpl_status});
        chk("cpl_tag", {48'h0, req_tag}, {48'h0, cpl_tag});
        if (st == `VBRE_ST_UNSUPP) chk("n_ops", ops0, n_ops);
        else chk("be_off", t == `VBRE_T_FLUSH ? 64'h0 : s << 9, last_off);
        repeat (2) @(posedge pclk);
        cpl_ready <= 1'b1;
        @(posedge pclk);
        cpl_ready <= 1'b0;
    endtask
    initial begin
        {presetn, psel, penable, pwrite, req_valid, cpl_ready, fail} = '0;
        {paddr, pwdata, req_type, req_reserved, req_sector} = '0;
        {req_tag, req_chunks, delay} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`VBRE_OFF_DEV_FEAT, 32'h0000_0e56, "dev_feat");
        rd(`VBRE_OFF_CAP_LO, CAP[31:0], "cap_lo");
        rd(`VBRE_OFF_CAP_HI, CAP[63:32], "cap_hi");
        rd(`VBRE_OFF_SEG_SIZE, SEG, "seg_size");
        rd(`VBRE_OFF_HEADS, {24'h0, HDS}, "heads");
        apb(1'b1, `VBRE_OFF_DEV_FEAT, 32'hffff_ffff);
        rd(12'h100, 32'h0, "unmapped");
        chk("pslverr", 64'h1, {63'h0, e});
        rd(`VBRE_OFF_DEV_FEAT, 32'h0000_0e56, "ro_feat");
        apb(1'b1, `VBRE_OFF_DRV_FEAT, 32'h0000_0800);
        apb(1'b1, `VBRE_OFF_DEV_STAT, 32'h0000_0008);
        rd(`VBRE_OFF_CACHE, 32'h0, "cache_init");
        for (k = 1; k >= 0; k = k - 1) begin
            apb(1'b1, `VBRE_OFF_CACHE, k);
            rd(`VBRE_OFF_CACHE, k, "cache_rw");
        end
        req(`VBRE_T_READ, 64'h3, `VBRE_ST_OK, 1'b0, 4'h0);
        req(`VBRE_T_WRITE, 64'h1_0000_0001, `VBRE_ST_OK, 1'b0, 4'h3);
        req(`VBRE_T_WRITE, 64'h7, `VBRE_ST_IOERR, 1'b1, 4'h1);
        req(`VBRE_T_FLUSH, 64'h0, `VBRE_ST_OK, 1'b0, 4'h2);
        req(32'h2, 64'h0, `VBRE_ST_UNSUPP, 1'b0, 4'h0);
        req(32'h5, 64'h0, `VBRE_ST_UNSUPP, 1'b0, 4'h0);
        req(32'h0800_0000, 64'h0, `VBRE_ST_UNSUPP, 1'b0, 4'h0);
        apb(1'b1, `VBRE_OFF_CTRL, 32'h0000_0001);
        rd(`VBRE_OFF_DEV_FEAT, 32'h0000_0ed7, "legacy_feat");
        apb(1'b1, `VBRE_OFF_CTRL, 32'h0000_0003);
        rd(`VBRE_OFF_CAP_LO, 32'h0100_0000, "cap_lo_be");
        rd(`VBRE_OFF_SEG_SIZE, 32'h0020_0000, "seg_size_be");
        apb(1'b1, `VBRE_OFF_CTRL, 32'h0000_0001);
        apb(1'b1, `VBRE_OFF_CACHE, 32'h1);
        apb(1'b1, `VBRE_OFF_DRV_FEAT, 32'h0000_0800);
        rd(`VBRE_OFF_CACHE, 32'h1, "cache_feat");
        apb(1'b1, `VBRE_OFF_DEV_STAT, 32'h0000_0004);
        rd(`VBRE_OFF_CACHE, 32'h1, "cache_ok_swc");
        apb(1'b1, `VBRE_OFF_DRV_FEAT, 32'h0);
        apb(1'b1, `VBRE_OFF_DEV_STAT, 32'h0);
        apb(1'b1, `VBRE_OFF_DEV_STAT, 32'h0000_0004);
        rd(`VBRE_OFF_CACHE, 32'h0, "cache_ok_noswc");
        wrap_up;
    end
endmodule
